// file: logic/spp_pkg.sv
package spp_pkg;

  // Port count and field widths
  localparam int NPORT  = 8;
  localparam int PW     = 3;
  localparam int RATE_W = 3;
  localparam int MIR_W  = PW + 1;
  localparam int FIFO_D = 16;

  // Mirroring direction mode
  typedef enum logic [1:0] {
    SPP_MIR_OFF  = 2'b00,
    SPP_MIR_TX   = 2'b01,
    SPP_MIR_BOTH = 2'b10
  } spp_mir_mode_t;

  // Ingress limiter frame class
  typedef enum logic [1:0] {
    SPP_CLS_ALL = 2'b00,
    SPP_CLS_BMU = 2'b01,
    SPP_CLS_BM  = 2'b10,
    SPP_CLS_B   = 2'b11
  } spp_cls_t;

  // Rate code that turns a limiter off
  localparam logic [RATE_W-1:0] RATE_OFF = 3'h0;

  // Reset values of the per-port and global settings
  localparam logic          RST_ENABLE   = 1'b1;
  localparam logic          RST_AUTO     = 1'b1;
  localparam logic          RST_SPEED100 = 1'b1;
  localparam logic          RST_FULL     = 1'b1;
  localparam logic          RST_FC_EN    = 1'b0;
  localparam logic          RST_FC_ASYM  = 1'b0;
  localparam logic          RST_MONITOR  = 1'b0;
  localparam spp_cls_t      RST_CLS      = SPP_CLS_BMU;
  localparam spp_mir_mode_t RST_MIR_MODE = SPP_MIR_OFF;
  localparam logic [PW-1:0] RST_ANA_PORT = 3'h0;

  // Timing: limiter measuring window
  localparam int CLK_HZ       = 20_000_000;
  localparam int WIN_US       = 1000;
  localparam int WIN_CYC      = WIN_US * (CLK_HZ / 1_000_000);
  localparam int FRM_PER_STEP = 16;

endpackage : spp_pkg

// file: logic/spp_fifo.sv
`timescale 1ns/1ns
module spp_fifo #(
  parameter int W = 4,
  parameter int D = 16
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);

  if (D < 2 || (1 << AW) != D) $error("spp_fifo depth must be a power of two");

  logic [W-1:0] mem_ff [D];
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] rp_ff;
  logic [AW:0]   cnt_ff;
  logic          push;
  logic          pop;

  // Honest flags straight from the fill count
  assign in_ready  = (cnt_ff != (AW+1)'(D));
  assign out_valid = (cnt_ff != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_ff[rp_ff];

  // Storage has no reset; only pointers and fill count need defined values
  always_ff @(posedge ref_clk)
  begin
    if (push)
      mem_ff[wp_ff] <= in_data;
  end

  // Pointers and fill count
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      if (push)
        wp_ff <= wp_ff + 1'b1;
      if (pop)
        rp_ff <= rp_ff + 1'b1;
      if (push && !pop)
        cnt_ff <= cnt_ff + 1'b1;
      else if (pop && !push)
        cnt_ff <= cnt_ff - 1'b1;
    end
  end

endmodule : spp_fifo

// file: logic/spp_rate_lim.sv
`timescale 1ns/1ns
module spp_rate_lim
  import spp_pkg::*;
#(
  parameter int CNT_W = 12,
  parameter int STEP  = 16
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // Window and counted frames
  input  wire logic              win_tick,
  input  wire logic              hit,
  input  wire logic [RATE_W-1:0] limit,
  // Budget of this window spent
  output logic                   over
);
  if (STEP < 1 || STEP * ((1 << RATE_W) - 1) >= (1 << CNT_W))
    $error("spp_rate_lim counter too narrow for the step");

  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] cap;

  // Frames allowed per window scale with the rate code
  assign cap  = CNT_W'(limit) * CNT_W'(STEP);
  assign over = (limit != RATE_OFF) && (cnt_ff >= cap);

  // Frame count within the current window; saturates, never wraps
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      cnt_ff <= '0;
    else if (win_tick)
      cnt_ff <= '0;
    else if (hit && cnt_ff != '1)
      cnt_ff <= cnt_ff + 1'b1;
  end

endmodule : spp_rate_lim

// file: logic/spp_policy.sv
`timescale 1ns/1ns
// Overview of operation
// [R1] Disabled port drops all received frames and transmits nothing.
// [R2] Auto negotiation: speed and duplex come from the link partner exchange.
// [R3] Forced: port runs at configured speed and duplex, negotiation off.
// [R4] Speed and duplex settings accept writes only when negotiation is forced.
// [R5] Per-port flow control symmetric or asymmetric, effective in full duplex only.
// [R6] Mirroring copies selected-direction frames of monitored ports; originals still forwarded.
// [R7] Mirror mode is off, transmit only, or both; resets to off.
// [R8] A single analysis port receives all mirrored copies.
// [R9] Each port has its own monitor flag; copies merge onto analysis port.
// [R10] Ingress limiter class: all, bcast/mcast/unknown, bcast/mcast, or bcast only.
// [R11] Egress limiter counts every frame; class affects ingress only.
// [R12] Per-port ingress rate, off value is the reset default.
// [R13] Per-port egress rate, off value is the reset default.
// [R14] Nonzero limit drops or holds frames exceeding budget per fixed window.
// [R15] Actual speed, duplex, flow control reported while up, unavailable while down.
module spp_policy
  import spp_pkg::*;
#(
  parameter int WIN_CYCLES = WIN_CYC,
  parameter int STEP       = FRM_PER_STEP,
  parameter int DEPTH      = FIFO_D
) (
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  // Per-port configuration write
  input  wire logic                    cfg_wr,
  input  wire logic [PW-1:0]           cfg_port,
  input  wire logic                    cfg_enable,
  input  wire logic                    cfg_auto,
  input  wire logic                    cfg_speed100,
  input  wire logic                    cfg_full,
  input  wire logic                    cfg_fc_en,
  input  wire logic                    cfg_fc_asym,
  input  wire spp_cls_t                cfg_cls,
  input  wire logic [RATE_W-1:0]       cfg_in_rate,
  input  wire logic [RATE_W-1:0]       cfg_eg_rate,
  input  wire logic                    cfg_monitor,
  // Global mirroring configuration write
  input  wire logic                    mir_wr,
  input  wire spp_mir_mode_t           mir_mode,
  input  wire logic [PW-1:0]           mir_ana_port,
  // Configuration readback
  output logic [NPORT-1:0]             st_enable_ff,
  output logic [NPORT-1:0]             st_auto_ff,
  output logic [NPORT-1:0]             st_speed100_ff,
  output logic [NPORT-1:0]             st_full_ff,
  output logic [NPORT-1:0]             st_fc_en_ff,
  output logic [NPORT-1:0]             st_fc_asym_ff,
  output logic [NPORT-1:0]             st_monitor_ff,
  output spp_mir_mode_t                st_mir_mode_ff,
  output logic [PW-1:0]                st_ana_port_ff,
  // Link partner results from the PHYs
  input  wire logic [NPORT-1:0]        link_up,
  input  wire logic [NPORT-1:0]        an_speed100,
  input  wire logic [NPORT-1:0]        an_full,
  input  wire logic [NPORT-1:0]        an_pause,
  // PHY control
  output logic [NPORT-1:0]             phy_an_en_ff,
  output logic [NPORT-1:0]             phy_speed100_ff,
  output logic [NPORT-1:0]             phy_full_ff,
  // Actual port status
  output logic [NPORT-1:0]             act_valid_ff,
  output logic [NPORT-1:0]             act_speed100_ff,
  output logic [NPORT-1:0]             act_full_ff,
  output logic [NPORT-1:0]             act_pause_tx_ff,
  output logic [NPORT-1:0]             act_pause_rx_ff,
  // Ingress frame descriptors
  input  wire logic [NPORT-1:0]        rx_valid,
  output logic [NPORT-1:0]             rx_ready,
  input  wire logic [NPORT-1:0]        rx_bcast,
  input  wire logic [NPORT-1:0]        rx_mcast,
  input  wire logic [NPORT-1:0]        rx_unk_ucast,
  output logic [NPORT-1:0]             rx_fwd_ff,
  output logic [NPORT-1:0]             rx_drop_ff,
  // Egress frame requests
  input  wire logic [NPORT-1:0]        tx_valid,
  output logic [NPORT-1:0]             tx_ready,
  output logic [NPORT-1:0]             tx_sent_ff,
  // Mirror copies toward the analysis port
  output logic                         ana_valid,
  input  wire logic                    ana_ready,
  output logic [PW-1:0]                ana_src_port,
  output logic                         ana_dir_tx
);
  if (NPORT != (1 << PW)) $error("spp_policy port count must match index width");
  if (WIN_CYCLES < 2) $error("spp_policy window too short");

  localparam int WCW   = $clog2(WIN_CYCLES);
  localparam int CNT_W = $clog2(STEP * ((1 << RATE_W) - 1) + 1) + 1;

  spp_cls_t          cls_ff  [NPORT];
  logic [RATE_W-1:0] irate_ff[NPORT];
  logic [RATE_W-1:0] erate_ff[NPORT];
  logic [WCW-1:0]    win_ff;
  logic              win_tick;
  logic [NPORT-1:0]  cls_hit;
  logic [NPORT-1:0]  in_over;
  logic [NPORT-1:0]  eg_over;
  logic [NPORT-1:0]  rx_pass;
  logic [NPORT-1:0]  tx_ok;
  logic [NPORT-1:0]  mon_eff;
  logic [NPORT-1:0]  rx_need;
  logic [NPORT-1:0]  tx_need;
  logic [2*NPORT-1:0] need;
  logic [2*NPORT-1:0] gnt;
  logic [NPORT-1:0]  rx_fire;
  logic [NPORT-1:0]  tx_fire;
  logic [NPORT-1:0]  spd;
  logic [NPORT-1:0]  ful;
  logic              cp_ready;
  logic [MIR_W-1:0]  cp_data;
  logic [MIR_W-1:0]  ana_data;

  // Lowest set request wins; fixed priority keeps the merge simple
  function automatic logic [2*NPORT-1:0] spp_pick(input logic [2*NPORT-1:0] req);
    return req & (~req + 1'b1);
  endfunction : spp_pick

  // Port state, negotiation and monitor flags
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      st_enable_ff  <= {NPORT{RST_ENABLE}};
      st_auto_ff    <= {NPORT{RST_AUTO}};
      st_fc_en_ff   <= {NPORT{RST_FC_EN}};
      st_fc_asym_ff <= {NPORT{RST_FC_ASYM}};
      st_monitor_ff <= {NPORT{RST_MONITOR}};
    end
    else if (cfg_wr)
    begin
      st_enable_ff[cfg_port]  <= cfg_enable;
      st_auto_ff[cfg_port]    <= cfg_auto;
      st_fc_en_ff[cfg_port]   <= cfg_fc_en;   // [R5]
      st_fc_asym_ff[cfg_port] <= cfg_fc_asym; // [R5]
      st_monitor_ff[cfg_port] <= cfg_monitor; // [R9]
    end
  end

  // Speed and duplex settings are frozen while negotiation is automatic
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      st_speed100_ff <= {NPORT{RST_SPEED100}};
      st_full_ff     <= {NPORT{RST_FULL}};
    end
    else if (cfg_wr && !cfg_auto) // [R4]
    begin
      st_speed100_ff[cfg_port] <= cfg_speed100;
      st_full_ff[cfg_port]     <= cfg_full;
    end
  end

  // Limiter class and rates; off is the reset default
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int p = 0; p < NPORT; p++)
      begin
        cls_ff[p]   <= RST_CLS;
        irate_ff[p] <= RATE_OFF; // [R12]
        erate_ff[p] <= RATE_OFF; // [R13]
      end
    end
    else if (cfg_wr)
    begin
      cls_ff[cfg_port]   <= cfg_cls;     // [R10]
      irate_ff[cfg_port] <= cfg_in_rate; // [R12]
      erate_ff[cfg_port] <= cfg_eg_rate; // [R13]
    end
  end

  // Global mirroring settings
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      st_mir_mode_ff <= RST_MIR_MODE; // [R7]
      st_ana_port_ff <= RST_ANA_PORT;
    end
    else if (mir_wr)
    begin
      st_mir_mode_ff <= mir_mode;     // [R7]
      st_ana_port_ff <= mir_ana_port; // [R8]
    end
  end

  // PHY control follows the stored negotiation settings
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      phy_an_en_ff    <= {NPORT{RST_AUTO}};
      phy_speed100_ff <= {NPORT{RST_SPEED100}};
      phy_full_ff     <= {NPORT{RST_FULL}};
    end
    else
    begin
      phy_an_en_ff    <= st_auto_ff;     // [R2]
      phy_speed100_ff <= st_speed100_ff; // [R3]
      phy_full_ff     <= st_full_ff;     // [R3]
    end
  end

  // Actual status; all zero means unavailable while link is down
  assign spd = (st_auto_ff & an_speed100) | (~st_auto_ff & st_speed100_ff); // [R2] [R3]
  assign ful = (st_auto_ff & an_full) | (~st_auto_ff & st_full_ff);         // [R2] [R3]
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      act_valid_ff    <= '0;
      act_speed100_ff <= '0;
      act_full_ff     <= '0;
      act_pause_tx_ff <= '0;
      act_pause_rx_ff <= '0;
    end
    else
    begin
      for (int p = 0; p < NPORT; p++)
      begin
        act_valid_ff[p]    <= link_up[p];                          // [R15]
        act_speed100_ff[p] <= link_up[p] & spd[p];                 // [R15]
        act_full_ff[p]     <= link_up[p] & ful[p];                 // [R15]
        // Pause only in full duplex; asymmetric sends pause but ignores it
        act_pause_tx_ff[p] <= link_up[p] & ful[p] & st_fc_en_ff[p]
                              & (st_fc_asym_ff[p] | an_pause[p]);  // [R5]
        act_pause_rx_ff[p] <= link_up[p] & ful[p] & st_fc_en_ff[p]
                              & ~st_fc_asym_ff[p] & an_pause[p];   // [R5]
      end
    end
  end

  // Shared measuring window for every limiter
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      win_ff <= '0;
    else if (win_tick)
      win_ff <= '0;
    else
      win_ff <= win_ff + 1'b1;
  end
  assign win_tick = (win_ff == WCW'(WIN_CYCLES - 1)); // [R14]

  // Frame class match for the ingress limiter
  always_comb
  begin
    for (int p = 0; p < NPORT; p++)
    begin
      case (cls_ff[p])
        SPP_CLS_ALL: cls_hit[p] = 1'b1;
        SPP_CLS_BMU: cls_hit[p] = rx_bcast[p] | rx_mcast[p] | rx_unk_ucast[p];
        SPP_CLS_BM:  cls_hit[p] = rx_bcast[p] | rx_mcast[p];
        default:     cls_hit[p] = rx_bcast[p];
      endcase
    end
  end

  // One ingress and one egress limiter per port
  for (genvar p = 0; p < NPORT; p++)
  begin : g_lim
    spp_rate_lim #(
      .CNT_W (CNT_W),
      .STEP  (STEP)
    ) u_in (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .win_tick (win_tick),
      .hit      (rx_fire[p] & rx_pass[p] & cls_hit[p]), // [R10]
      .limit    (irate_ff[p]),
      .over     (in_over[p])
    );
    spp_rate_lim #(
      .CNT_W (CNT_W),
      .STEP  (STEP)
    ) u_eg (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .win_tick (win_tick),
      .hit      (tx_fire[p]), // [R11]
      .limit    (erate_ff[p]),
      .over     (eg_over[p])
    );
  end

  // Forwarding decision; the analysis port never mirrors itself
  always_comb
  begin
    for (int p = 0; p < NPORT; p++)
    begin
      rx_pass[p] = st_enable_ff[p] & link_up[p] & ~(cls_hit[p] & in_over[p]); // [R1] [R14]
      tx_ok[p]   = st_enable_ff[p] & link_up[p] & ~eg_over[p];                // [R1] [R14]
      mon_eff[p] = st_monitor_ff[p] & (st_ana_port_ff != PW'(p));             // [R9]
    end
  end

  // Which frame events must place a copy before completing
  assign rx_need = rx_valid & rx_pass & mon_eff
                   & {NPORT{st_mir_mode_ff == SPP_MIR_BOTH}};                 // [R6]
  assign tx_need = tx_valid & tx_ok & mon_eff
                   & {NPORT{st_mir_mode_ff == SPP_MIR_TX
                            || st_mir_mode_ff == SPP_MIR_BOTH}};              // [R6]
  assign need    = {tx_need, rx_need};
  assign gnt     = spp_pick(need); // [R9]

  // A copy-bearing event waits for its grant and FIFO room
  assign rx_ready = ~rx_need | (gnt[NPORT-1:0] & {NPORT{cp_ready}});
  assign tx_ready = tx_ok & (~tx_need | (gnt[2*NPORT-1:NPORT] & {NPORT{cp_ready}}));
  assign rx_fire  = rx_valid & rx_ready;
  assign tx_fire  = tx_valid & tx_ready;

  // Copy descriptor: direction flag above the source port number
  always_comb
  begin
    cp_data = '0;
    for (int i = 0; i < 2*NPORT; i++)
    begin
      if (gnt[i])
        cp_data = {(i >= NPORT), PW'(i % NPORT)};
    end
  end

  // Frame completion pulses; a disabled or over-limit port drops
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rx_fwd_ff  <= '0;
      rx_drop_ff <= '0;
      tx_sent_ff <= '0;
    end
    else
    begin
      rx_fwd_ff  <= rx_fire & rx_pass;  // [R6]
      rx_drop_ff <= rx_fire & ~rx_pass; // [R1] [R14]
      tx_sent_ff <= tx_fire;
    end
  end

  // Copies queue here; a slow analyzer stalls monitored ports
  spp_fifo #(
    .W (MIR_W),
    .D (DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .in_valid  (|need),
    .in_ready  (cp_ready),
    .in_data   (cp_data),
    .out_valid (ana_valid),
    .out_ready (ana_ready),
    .out_data  (ana_data)
  );

  assign ana_dir_tx   = ana_data[MIR_W-1];
  assign ana_src_port = ana_data[PW-1:0];

endmodule : spp_policy

// file: testbench/spp_policy_props.sv
`timescale 1ns/1ns
module spp_policy_chk
  import spp_pkg::*;
(
  // Clock and reset
  input wire logic             ref_clk,
  input wire logic             rst,
  // Configuration
  input wire logic             cfg_wr,
  input wire logic             cfg_auto,
  input wire logic [NPORT-1:0] st_enable_ff,
  input wire logic [NPORT-1:0] st_auto_ff,
  input wire logic [NPORT-1:0] st_speed100_ff,
  input wire logic [NPORT-1:0] st_monitor_ff,
  input wire spp_mir_mode_t    st_mir_mode_ff,
  input wire logic [PW-1:0]    st_ana_port_ff,
  // Link and PHY
  input wire logic [NPORT-1:0] link_up,
  input wire logic [NPORT-1:0] phy_an_en_ff,
  input wire logic [NPORT-1:0] phy_speed100_ff,
  input wire logic [NPORT-1:0] act_valid_ff,
  // Traffic
  input wire logic [NPORT-1:0] rx_valid,
  input wire logic [NPORT-1:0] rx_ready,
  input wire logic [NPORT-1:0] rx_fwd_ff,
  input wire logic [NPORT-1:0] rx_drop_ff,
  input wire logic [NPORT-1:0] tx_valid,
  input wire logic [NPORT-1:0] tx_ready,
  input wire logic [NPORT-1:0] tx_sent_ff,
  input wire logic             ana_valid,
  input wire logic             ana_ready,
  input wire logic [PW-1:0]    ana_src_port,
  input wire logic             ana_dir_tx
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Handshakes; the analysis port itself is never a mirror source
  logic [NPORT-1:0] rx_hs, tx_hs, dis_hs, mon_tx;
  assign rx_hs  = rx_valid & rx_ready;
  assign tx_hs  = tx_valid & tx_ready;
  assign dis_hs = rx_hs & ~st_enable_ff;
  assign mon_tx = tx_hs & st_monitor_ff & ~(8'h01 << st_ana_port_ff);

  sequence tx_copy_s;
    (mon_tx != 8'h00) && (st_mir_mode_ff inside {SPP_MIR_TX, SPP_MIR_BOTH});
  endsequence
  sequence copy_out_s;
    ##[1:3] ana_valid;
  endsequence

  AST_DIS_TX: assert property ((tx_ready & ~st_enable_ff) == 8'h00)
    else $error("tx ready on a disabled port");
  AST_DIS_RX: assert property (dis_hs != 8'h00 |=> (rx_drop_ff & $past(dis_hs)) == $past(dis_hs))
    else $error("disabled port frame not dropped");
  AST_RX_ANS: assert property (##1 (rx_fwd_ff | rx_drop_ff) == $past(rx_hs) && (rx_fwd_ff & rx_drop_ff) == 8'h00)
    else $error("rx verdict does not match handshake");
  AST_TX_ANS: assert property (tx_sent_ff == $past(tx_hs))
    else $error("tx sent pulse does not match handshake");
  AST_PHY: assert property (phy_an_en_ff == $past(st_auto_ff) && phy_speed100_ff == $past(st_speed100_ff))
    else $error("phy control does not follow settings");
  AST_AUTO_KEEP: assert property (cfg_wr && cfg_auto |=> st_speed100_ff == $past(st_speed100_ff))
    else $error("speed written while negotiation automatic");
  AST_ACT_DOWN: assert property ((act_valid_ff & ~link_up & ~$past(link_up) & ~$past(link_up, 2)) == 8'h00)
    else $error("status valid on a down link");
  AST_MIR_TX: assert property (tx_copy_s |-> copy_out_s)
    else $error("tx copy missing on analysis side");
  AST_MIR_OFF: assert property (st_mir_mode_ff == SPP_MIR_OFF && !ana_valid |=> !ana_valid)
    else $error("copy made with mirroring off");
  AST_ANA_HOLD: assert property (ana_valid && !ana_ready |=> ana_valid && $stable(ana_src_port) && $stable(ana_dir_tx))
    else $error("analysis head changed while stalled");
endmodule : spp_policy_chk

bind spp_policy spp_policy_chk spp_policy_chk_i (.*);

// file: testbench/spp_link_peer.sv
`timescale 1ns/1ns
module spp_link_peer
  import spp_pkg::*;
#(
  parameter logic [NPORT-1:0] SPD = 8'h0f,
  parameter logic [NPORT-1:0] FUL = 8'hfb,
  parameter logic [NPORT-1:0] PAU = 8'h01
) (
  // Bench control
  input  wire logic [NPORT-1:0] link_mask,
  input  wire logic             hold,
  // Toward the block
  output logic [NPORT-1:0]      link_up,
  output logic [NPORT-1:0]      an_speed100,
  output logic [NPORT-1:0]      an_full,
  output logic [NPORT-1:0]      an_pause,
  output logic                  ana_ready
);
  // Abilities only reported while up; a down PHY advertises nothing
  assign link_up     = link_mask;
  assign an_speed100 = SPD & link_mask;
  assign an_full     = FUL & link_mask;
  assign an_pause    = PAU & link_mask;
  // Analyser sink, stalls when asked
  assign ana_ready   = ~hold;
endmodule : spp_link_peer

// file: testbench/spp_policy_test.sv
`timescale 1ns/1ns
module spp_policy_test;
  import spp_pkg::*;
  logic              ref_clk, rst, cfg_wr, cfg_enable, cfg_auto, cfg_speed100, cfg_full;
  logic              cfg_fc_en, cfg_fc_asym, cfg_monitor, mir_wr, hold, f;
  logic              ana_valid, ana_ready, ana_dir_tx;
  logic [PW-1:0]     cfg_port, mir_ana_port, st_ana_port_ff, ana_src_port;
  logic [RATE_W-1:0] cfg_in_rate, cfg_eg_rate;
  spp_cls_t          cfg_cls;
  spp_mir_mode_t     mir_mode, st_mir_mode_ff;
  logic [NPORT-1:0]  st_enable_ff, st_auto_ff, st_speed100_ff, st_full_ff, st_fc_en_ff;
  logic [NPORT-1:0]  st_fc_asym_ff, st_monitor_ff, link_up, an_speed100, an_full, an_pause;
  logic [NPORT-1:0]  phy_an_en_ff, phy_speed100_ff, phy_full_ff, act_valid_ff, act_speed100_ff;
  logic [NPORT-1:0]  act_full_ff, act_pause_tx_ff, act_pause_rx_ff, rx_valid, rx_ready, rx_bcast;
  logic [NPORT-1:0]  rx_mcast, rx_unk_ucast, rx_fwd_ff, rx_drop_ff, tx_valid, tx_ready;
  logic [NPORT-1:0]  tx_sent_ff, link_mask;
  logic [2:0]        kind [4] = '{3'b000, 3'b000, 3'b001, 3'b010};
  logic              fexp [4] = '{1'b0, 1'b1, 1'b1, 1'b1};
  int                failures, n_tests, n, k, w;

  spp_policy #(.WIN_CYCLES(64), .STEP(2), .DEPTH(16)) spp_policy_i (.*);
  spp_link_peer spp_link_peer_i (.*);

  // Clock
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic wr_cfg(input logic [2:0] p, input logic en, au, sp, fu, fe, fa, mo,
                        input spp_cls_t cl, input logic [2:0] ir, er);
    @(negedge ref_clk);
    {cfg_port, cfg_enable, cfg_auto, cfg_speed100, cfg_full} = {p, en, au, sp, fu};
    {cfg_fc_en, cfg_fc_asym, cfg_monitor, cfg_cls} = {fe, fa, mo, cl};
    {cfg_in_rate, cfg_eg_rate, cfg_wr} = {ir, er, 1'b1};
    @(negedge ref_clk);
    cfg_wr = 1'b0;
  endtask : wr_cfg

  task automatic wr_mir(input spp_mir_mode_t m, input logic [2:0] a);
    @(negedge ref_clk);
    {mir_mode, mir_ana_port, mir_wr} = {m, a, 1'b1};
    @(negedge ref_clk);
    mir_wr = 1'b0;
  endtask : wr_mir

  // One descriptor; fw tells forwarded or dropped
  task automatic rx(input int p, input logic [2:0] kd, output logic fw);
    int t;
    @(negedge ref_clk);
    {rx_bcast[p], rx_mcast[p], rx_unk_ucast[p], rx_valid[p]} = {kd, 1'b1};
    #1; // Let ready react to the raised valid
    for (t = 0; t < 100 && rx_ready[p] !== 1'b1; t++) @(negedge ref_clk);
    @(negedge ref_clk);
    rx_valid[p] = 1'b0;
    fw = rx_fwd_ff[p];
    if (t == 100) chk("rx_ready", 8'h01, 8'h00);
  endtask : rx

  // One frame out; wt is cycles held back, 200 means never sent
  task automatic tx(input int p, output int wt);
    @(negedge ref_clk);
    tx_valid[p] = 1'b1;
    #1;
    for (wt = 0; wt < 200 && tx_ready[p] !== 1'b1; wt++) @(negedge ref_clk);
    @(negedge ref_clk);
    tx_valid[p] = 1'b0;
  endtask : tx

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim

  // Watchdog, well beyond the thousand or so cycles the tests need
  initial
  begin
    #1_000_000;
    failures++;
    end_sim();
  end

  // Tests
  initial
  begin
    {cfg_wr, cfg_port, cfg_enable, cfg_auto, cfg_speed100, cfg_full} = '0;
    {cfg_fc_en, cfg_fc_asym, cfg_monitor, cfg_in_rate, cfg_eg_rate, mir_wr} = '0;
    {cfg_cls, mir_mode, mir_ana_port, rx_valid, rx_bcast, rx_mcast, rx_unk_ucast} = '0;
    {tx_valid, hold, failures, n_tests} = '0;
    link_mask = 8'h7f;
    rst = 1'b1;
    repeat (16) @(negedge ref_clk);
    rst = 1'b0;
    chk("enable", 8'hff, st_enable_ff);
    chk("mir_mode", {6'h00, SPP_MIR_OFF}, {6'h00, st_mir_mode_ff});
    chk("phy_an", 8'hff, phy_an_en_ff);
    wr_cfg(0, 1, 1, 1, 1, 1, 0, 0, SPP_CLS_BMU, 3'h0, 3'h0);
    wr_cfg(1, 1, 1, 1, 1, 1, 1, 0, SPP_CLS_BMU, 3'h0, 3'h0);
    wr_cfg(2, 1, 1, 1, 1, 1, 0, 0, SPP_CLS_BMU, 3'h0, 3'h0);
    repeat (4) @(negedge ref_clk);
    chk("act_valid", 8'h7f, act_valid_ff);
    chk("act_speed", 8'h0f, act_speed100_ff);
    chk("act_full", 8'h7b, act_full_ff);
    chk("pause_tx", 8'h03, act_pause_tx_ff);
    chk("pause_rx", 8'h01, act_pause_rx_ff);
    chk("fc_cfg", 8'h27, {st_fc_asym_ff[3:0], st_fc_en_ff[3:0]});
    $display("test status done");
    wr_cfg(2, 1, 0, 0, 0, 0, 0, 0, SPP_CLS_BMU, 3'h0, 3'h0);
    repeat (4) @(negedge ref_clk);
    chk("st_speed", 8'hfb, st_speed100_ff);
    chk("phy_an", 8'hfb, phy_an_en_ff);
    chk("act_speed", 8'h0b, act_speed100_ff);
    chk("full", 8'hfb, st_full_ff & phy_full_ff);
    wr_cfg(2, 1, 1, 1, 1, 0, 0, 0, SPP_CLS_BMU, 3'h0, 3'h0);
    chk("st_speed", 8'hfb, st_speed100_ff);
    chk("st_auto", 8'hff, st_auto_ff);
    $display("test forced done");
    for (n = 0; n < 2; n++)
    begin
      wr_cfg(3, n[0], 1, 1, 1, 0, 0, 0, SPP_CLS_BMU, 3'h0, 3'h0);
      rx(3, 3'b100, f);
      chk("rx_en", {7'h00, n[0]}, {7'h00, f});
      tx(3, w);
      chk("tx_held", {7'h00, n[0]}, {7'h00, w < 200});
    end
    $display("test disable done");
    for (n = 0; n < 6; n++)
    begin
      rx(5, 3'b100, f);
      chk("in_off", 8'h01, {7'h00, f});
      tx(5, w);
      chk("eg_off", 8'h00, w[7:0]);
    end
    // Spend the budget, then sync to a fresh window before judging the class
    for (k = 0; k < 4; k++)
    begin
      wr_cfg(4, 1, 1, 1, 1, 0, 0, 0, spp_cls_t'(k), 3'h1, 3'h0);
      f = 1'b1;
      for (n = 0; n < 8 && f; n++) rx(4, 3'b100, f);
      for (n = 0; n < 40 && !f; n++) rx(4, 3'b100, f);
      rx(4, 3'b100, f);
      chk("in_2nd", 8'h01, {7'h00, f});
      rx(4, kind[k], f);
      chk("in_cls", {7'h00, fexp[k]}, {7'h00, f});
      rx(4, 3'b100, f);
      chk("in_over", 8'h00, {7'h00, f});
    end
    wr_cfg(6, 1, 1, 1, 1, 0, 0, 0, SPP_CLS_B, 3'h0, 3'h1);
    w = 0;
    for (n = 0; n < 8 && w < 3; n++) tx(6, w);
    tx(6, w);
    chk("eg_2nd", 8'h00, w[7:0]);
    tx(6, w);
    chk("eg_held", 8'h01, {7'h00, w > 3});
    $display("test limiters done");
    hold = 1'b1;
    wr_mir(SPP_MIR_TX, 3'h7);
    wr_cfg(0, 1, 1, 1, 1, 1, 0, 1, SPP_CLS_BMU, 3'h0, 3'h0);
    wr_cfg(1, 1, 1, 1, 1, 1, 1, 1, SPP_CLS_BMU, 3'h0, 3'h0);
    chk("mon_ana", 8'h1f, {st_monitor_ff[4:0], st_ana_port_ff});
    rx(1, 3'b000, f);
    repeat (2) @(negedge ref_clk);
    chk("ana_rx_tx", 8'h00, {7'h00, ana_valid});
    for (k = 0; k < 2; k++)
    begin
      if (k == 0) tx(0, w);
      else rx(1, 3'b000, f);
      repeat (2) @(negedge ref_clk);
      chk("ana_head", {4'h1, 1'b1, 3'(k)}, {3'h0, ana_valid, ana_dir_tx ^ k[0], ana_src_port});
      hold = 1'b0;
      @(negedge ref_clk);
      hold = 1'b1;
      wr_mir(SPP_MIR_BOTH, 3'h7);
    end
    chk("fwd_orig", 8'h01, {7'h00, f});
    for (n = 0; n < 16; n++) tx(0, w);
    tx(0, w);
    chk("fifo_full", 8'h01, {7'h00, w == 200});
    hold = 1'b0;
    k = 0;
    for (n = 0; n < 40; n++)
    begin
      if (ana_valid === 1'b1) k++;
      @(negedge ref_clk);
    end
    chk("drained", 8'h10, k[7:0]);
    wr_mir(SPP_MIR_OFF, 3'h7);
    tx(0, w);
    repeat (3) @(negedge ref_clk);
    chk("mir_off", 8'h00, {7'h00, ana_valid});
    $display("test mirror done");
    end_sim();
  end
endmodule : spp_policy_test
